/* File: hdl/mis_pkg.sv */
// mis_pkg: constants, opcode enum and carriers of the instruction sequencer.
// assumes a 16-bit program word and a 7-bit data memory address space.
package mis_pkg;
  // one instruction cycle spans this many system clocks
  localparam int CLKS_PER_CYCLE = 4;
  localparam int PH_W = 2;
  localparam logic [1:0] PH_LAST = 2'h3;
  localparam logic [1:0] PH_WRITE = 2'h2;
  // instruction word fields
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 10;
  localparam int BIT_MSB = 9;
  localparam int BIT_LSB = 7;
  localparam int ADR_MSB = 6;
  localparam int IMM_MSB = 7;
  localparam int TGT_MSB = 9;
  localparam int DA_W = 7;
  // data address that maps onto the low byte of the program counter
  localparam logic [6:0] PC_LOW_BYTE_ADDR = 7'h06;
  // reset values and default sizes
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] IR_RST = 16'h0000;
  localparam int PC_W_DEF = 10;
  localparam int STACK_DEPTH_DEF = 8;

  typedef enum logic [5:0] {
    OP_NOP, OP_XFER_A_M, OP_XFER_M_A, OP_XFER_A_X,
    OP_ADD_A_M, OP_ADC_A_M, OP_SUB_A_M, OP_SBC_A_M, OP_ADD_A_X, OP_SUB_A_X, OP_ADD_M_A,
    OP_AND_A_M, OP_OR_A_M, OP_XOR_A_M, OP_AND_M_A, OP_OR_M_A, OP_XOR_M_A,
    OP_AND_A_X, OP_OR_A_X, OP_XOR_A_X, OP_INVERT_MEM, OP_INVERT_ACC,
    OP_PLUS1_MEM, OP_PLUS1_ACC, OP_MINUS1_MEM, OP_MINUS1_ACC,
    OP_ROT_R, OP_ROT_L, OP_ROT_RC, OP_ROT_LC, OP_SET_BIT, OP_CLR_BIT,
    OP_SKIP_ZERO, OP_SKIP_BIT0, OP_SKIP_BIT1, OP_GOTO, OP_CALL,
    OP_SUB_RETURN, OP_INT_RETURN, OP_TABLE_READ, OP_HALT, OP_WDT_CLEAR
  } mis_op_e;

  typedef struct packed {
    logic z;
    logic c;
  } mis_flags_s;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic we;
  } mis_dm_s;
endpackage : mis_pkg

/* File: hdl/mis_core.sv */
// mis_core: instruction sequencer and datapath of an 8-bit accumulator core.
// assumes program and data memories answer combinationally on the same clock.
`timescale 1ns/10ps

// Functional notes
// - four clocks form one instruction cycle
// - branches, calls, returns, table reads take two
// - writing pc low byte jumps, one extra cycle
// - skip costs two cycles, no skip one
// - skip tests a memory byte or bit
// - call saves next address, return restores it
// - three transfer forms to and from accumulator
// - carry above 255, borrow below zero
// - plus or minus one, memory or accumulator
// - logic ops use accumulator; invert memory operand
// - logic ops update zero flag
// - rotate by one, carry variants through carry
// - bit set/clear changes only that bit
// - table read fetches program memory into data
// - halt powers down; separate watchdog clear
module mis_core #(
  parameter int PC_W = mis_pkg::PC_W_DEF,
  parameter int STACK_DEPTH = mis_pkg::STACK_DEPTH_DEF
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // program memory
  output logic [PC_W-1:0] PM_ADDR_O,
  input wire logic [15:0] PM_DATA_I,
  // data memory
  output mis_pkg::mis_dm_s DM_O,
  input wire logic [7:0] DM_RDATA_I,
  // wake-up pin, asynchronous
  input wire logic WAKE_I,
  // core state
  output logic [7:0] ACC_O,
  output mis_pkg::mis_flags_s FLAGS_O,
  output logic [7:0] TBL_HIGH_O,
  output logic HALT_O,
  output logic INT_EN_O,
  output logic WDT_CLR_O,
  output logic CYCLE_END_O
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  // the pc low byte mapping needs page bits above it
  if (PC_W < 9 || PC_W > mis_pkg::TGT_MSB + 1)
  begin : g_bad_pc
    $error("PC_W must lie between 9 and 10");
  end
  if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH)
  begin : g_bad_stack
    $error("STACK_DEPTH must be a power of two");
  end
  // the phase counter wraps by itself only when the cycle length is a power of two
  if (mis_pkg::CLKS_PER_CYCLE != (1 << mis_pkg::PH_W))
  begin : g_bad_phase
    $error("CLKS_PER_CYCLE must equal two to the power PH_W");
  end

  // nine-bit sum: carry out in bit 8
  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b, input logic ci);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
  endfunction : add9

  localparam int PH_W_L = mis_pkg::PH_W;
  logic [PH_W_L-1:0] ph_r;
  logic cyc_end;
  logic [15:0] ir_r;
  logic [PC_W-1:0] pc_r;
  logic [7:0] acc_r;
  logic z_r;
  logic c_r;
  logic flush_r;
  logic tab_r;
  logic halt_r;
  logic wake_m_r;
  logic wake_s_r;
  logic [PC_W-1:0] stk_r [STACK_DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [6:0] addr_r;
  logic [7:0] wdata_r;
  logic we_r;
  logic [7:0] tblh_r;
  logic int_en_r;
  logic wdt_r;
  logic run;
  logic exec;
  mis_pkg::mis_op_e op;
  logic [2:0] bidx;
  logic [7:0] imm;
  logic [7:0] opnd;
  logic [PC_W-1:0] pc_cur;
  logic [PC_W-1:0] tab_addr;

  // execute results
  logic [7:0] res;
  logic wr_mem;
  logic wr_acc;
  logic upd_z;
  logic upd_c;
  logic c_new;
  logic skip;
  logic jump;
  logic push;
  logic pop;
  logic tab_go;
  logic halt_go;
  logic wdt_go;
  logic interrupt_return_go;
  logic pcl_wr;
  logic [8:0] sum;

  // phase counter: every instruction cycle is four clocks
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      ph_r <= '0;
    else
      ph_r <= ph_r + 2'h1;
  end
  assign cyc_end = (ph_r == mis_pkg::PH_LAST);

  // wake pin synchroniser
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      wake_m_r <= 1'b0;
      wake_s_r <= 1'b0;
    end
    else
    begin
      wake_m_r <= WAKE_I;
      wake_s_r <= wake_m_r;
    end
  end

  // decode; unknown codes behave as no operation
  assign op = mis_pkg::mis_op_e'(ir_r[mis_pkg::OP_MSB:mis_pkg::OP_LSB]);
  assign bidx = ir_r[mis_pkg::BIT_MSB:mis_pkg::BIT_LSB];
  assign imm = ir_r[mis_pkg::IMM_MSB:0];
  assign pc_cur = pc_r - {{(PC_W-1){1'b0}}, 1'b1};
  assign tab_addr = {pc_r[PC_W-1:8], acc_r};
  // reading the pc low byte location returns the executing address
  assign opnd = (addr_r == mis_pkg::PC_LOW_BYTE_ADDR) ? pc_cur[7:0] : DM_RDATA_I;
  // a discarded, stalled or halted cycle executes nothing
  assign run = !flush_r && !tab_r && !halt_r;
  assign exec = run && cyc_end;

  // datapath: one result byte, destination and flag effects
  always_comb
  begin
    res = acc_r;
    wr_mem = 1'b0;
    wr_acc = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    c_new = c_r;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    tab_go = 1'b0;
    halt_go = 1'b0;
    wdt_go = 1'b0;
    interrupt_return_go = 1'b0;
    sum = 9'h000;
    unique case (op)
      mis_pkg::OP_XFER_A_M: begin res = opnd; wr_acc = 1'b1; end
      mis_pkg::OP_XFER_M_A: begin res = acc_r; wr_mem = 1'b1; end
      mis_pkg::OP_XFER_A_X: begin res = imm; wr_acc = 1'b1; end
      mis_pkg::OP_ADD_A_M, mis_pkg::OP_ADC_A_M, mis_pkg::OP_ADD_A_X, mis_pkg::OP_ADD_M_A:
      begin
        sum = add9(acc_r, (op == mis_pkg::OP_ADD_A_X) ? imm : opnd, (op == mis_pkg::OP_ADC_A_M) && c_r);
        res = sum[7:0];
        c_new = sum[8];
        upd_c = 1'b1;
        upd_z = 1'b1;
        wr_acc = (op != mis_pkg::OP_ADD_M_A);
        wr_mem = (op == mis_pkg::OP_ADD_M_A);
      end
      mis_pkg::OP_SUB_A_M, mis_pkg::OP_SBC_A_M, mis_pkg::OP_SUB_A_X:
      begin
        // carry clear after a subtraction means a borrow occurred
        sum = add9(acc_r, ~((op == mis_pkg::OP_SUB_A_X) ? imm : opnd), (op != mis_pkg::OP_SBC_A_M) || c_r);
        res = sum[7:0];
        c_new = sum[8];
        upd_c = 1'b1;
        upd_z = 1'b1;
        wr_acc = 1'b1;
      end
      mis_pkg::OP_AND_A_M, mis_pkg::OP_AND_M_A, mis_pkg::OP_AND_A_X:
      begin
        res = acc_r & ((op == mis_pkg::OP_AND_A_X) ? imm : opnd);
        upd_z = 1'b1;
        wr_mem = (op == mis_pkg::OP_AND_M_A);
        wr_acc = !wr_mem;
      end
      mis_pkg::OP_OR_A_M, mis_pkg::OP_OR_M_A, mis_pkg::OP_OR_A_X:
      begin
        res = acc_r | ((op == mis_pkg::OP_OR_A_X) ? imm : opnd);
        upd_z = 1'b1;
        wr_mem = (op == mis_pkg::OP_OR_M_A);
        wr_acc = !wr_mem;
      end
      mis_pkg::OP_XOR_A_M, mis_pkg::OP_XOR_M_A, mis_pkg::OP_XOR_A_X:
      begin
        res = acc_r ^ ((op == mis_pkg::OP_XOR_A_X) ? imm : opnd);
        upd_z = 1'b1;
        wr_mem = (op == mis_pkg::OP_XOR_M_A);
        wr_acc = !wr_mem;
      end
      mis_pkg::OP_INVERT_MEM, mis_pkg::OP_INVERT_ACC:
      begin
        res = ~opnd;
        upd_z = 1'b1;
        wr_mem = (op == mis_pkg::OP_INVERT_MEM);
        wr_acc = !wr_mem;
      end
      mis_pkg::OP_PLUS1_MEM, mis_pkg::OP_PLUS1_ACC:
      begin
        res = opnd + 8'h01;
        upd_z = 1'b1;
        wr_mem = (op == mis_pkg::OP_PLUS1_MEM);
        wr_acc = !wr_mem;
      end
      mis_pkg::OP_MINUS1_MEM, mis_pkg::OP_MINUS1_ACC:
      begin
        res = opnd - 8'h01;
        upd_z = 1'b1;
        wr_mem = (op == mis_pkg::OP_MINUS1_MEM);
        wr_acc = !wr_mem;
      end
      mis_pkg::OP_ROT_R: begin res = {opnd[0], opnd[7:1]}; wr_mem = 1'b1; end
      mis_pkg::OP_ROT_L: begin res = {opnd[6:0], opnd[7]}; wr_mem = 1'b1; end
      mis_pkg::OP_ROT_RC:
      begin
        res = {c_r, opnd[7:1]};
        c_new = opnd[0];
        upd_c = 1'b1;
        wr_mem = 1'b1;
      end
      mis_pkg::OP_ROT_LC:
      begin
        res = {opnd[6:0], c_r};
        c_new = opnd[7];
        upd_c = 1'b1;
        wr_mem = 1'b1;
      end
      // read-modify-write keeps the other seven bits
      mis_pkg::OP_SET_BIT: begin res = opnd | (8'h01 << bidx); wr_mem = 1'b1; end
      mis_pkg::OP_CLR_BIT: begin res = opnd & ~(8'h01 << bidx); wr_mem = 1'b1; end
      mis_pkg::OP_SKIP_ZERO: skip = (opnd == 8'h00);
      mis_pkg::OP_SKIP_BIT0: skip = !opnd[bidx];
      mis_pkg::OP_SKIP_BIT1: skip = opnd[bidx];
      mis_pkg::OP_GOTO: jump = 1'b1;
      mis_pkg::OP_CALL: begin jump = 1'b1; push = 1'b1; end
      mis_pkg::OP_SUB_RETURN: pop = 1'b1;
      mis_pkg::OP_INT_RETURN: begin pop = 1'b1; interrupt_return_go = 1'b1; end
      mis_pkg::OP_TABLE_READ: tab_go = 1'b1;
      mis_pkg::OP_HALT: halt_go = 1'b1;
      mis_pkg::OP_WDT_CLEAR: wdt_go = 1'b1;
      default: res = acc_r;
    endcase
  end
  // a store to the pc low byte becomes a jump, not a memory write
  assign pcl_wr = wr_mem && (addr_r == mis_pkg::PC_LOW_BYTE_ADDR);

  // fetch pipeline and program counter
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      pc_r <= '0;
      ir_r <= mis_pkg::IR_RST;
      flush_r <= 1'b1;
      tab_r <= 1'b0;
    end
    else if (cyc_end && !halt_r)
    begin
      if (tab_r)
      begin
        tab_r <= 1'b0; // second cycle of a table read
      end
      else
      begin
        ir_r <= PM_DATA_I;
        tab_r <= run && tab_go;
        // skipped or stale fetch is discarded
        flush_r <= run && (skip || jump || pop || pcl_wr);
        if (run && jump)
          pc_r <= ir_r[PC_W-1:0];
        else if (run && pop)
          pc_r <= stk_r[sp_r - 1'b1];
        else if (run && pcl_wr)
          pc_r <= {pc_r[PC_W-1:8], res};
        else
          pc_r <= pc_r + {{(PC_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // stack pointer; overflow wraps silently
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      sp_r <= '0;
    else if (exec && push)
      sp_r <= sp_r + 1'b1;
    else if (exec && pop)
      sp_r <= sp_r - 1'b1;
  end

  // return address slots, no reset: pc_r already holds the address after the call
  always_ff @(posedge CLK_I)
  begin
    if (exec && push)
      stk_r[sp_r] <= pc_r;
  end

  // accumulator and flags change only in an executing cycle
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      acc_r <= mis_pkg::ACC_RST;
      z_r <= 1'b0;
      c_r <= 1'b0;
    end
    else if (exec)
    begin
      if (wr_acc)
        acc_r <= res;
      if (upd_z)
        z_r <= (res == 8'h00);
      if (upd_c)
        c_r <= c_new;
    end
  end

  // data memory port: address per instruction, write strobe in the last clock
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      addr_r <= '0;
      wdata_r <= 8'h00;
      we_r <= 1'b0;
      tblh_r <= 8'h00;
    end
    else
    begin
      if (ph_r == mis_pkg::PH_WRITE && !halt_r)
      begin
        we_r <= tab_r || (run && wr_mem && !pcl_wr);
        wdata_r <= tab_r ? PM_DATA_I[7:0] : res;
      end
      else
        we_r <= 1'b0;
      if (cyc_end && tab_r)
      begin
        tblh_r <= PM_DATA_I[15:8];
        addr_r <= ir_r[mis_pkg::ADR_MSB:0];
      end
      else if (cyc_end && !halt_r && !(run && tab_go))
        addr_r <= PM_DATA_I[mis_pkg::ADR_MSB:0];
    end
  end

  // power-down, interrupt enable and watchdog clear pulse
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      halt_r <= 1'b0;
      int_en_r <= 1'b0;
      wdt_r <= 1'b0;
    end
    else
    begin
      wdt_r <= exec && wdt_go;
      if (exec && halt_go)
        halt_r <= 1'b1;
      else if (wake_s_r && cyc_end)
        halt_r <= 1'b0;
      if (exec && interrupt_return_go)
        int_en_r <= 1'b1;
    end
  end

  // outputs
  assign PM_ADDR_O = tab_r ? tab_addr : pc_r;
  assign DM_O = '{addr: addr_r, wdata: wdata_r, we: we_r};
  assign ACC_O = acc_r;
  assign FLAGS_O = '{z: z_r, c: c_r};
  assign TBL_HIGH_O = tblh_r;
  assign HALT_O = halt_r;
  assign INT_EN_O = int_en_r;
  assign WDT_CLR_O = wdt_r;
  assign CYCLE_END_O = cyc_end;

endmodule : mis_core

/* File: tb/mis_chk_assertions.sv */
// mis_chk: port-level timing checks of the sequencer core.
// assumes it is bound into every mis_core instance.
`timescale 1ns/10ps
module mis_chk #(
  parameter int PC_W = 10
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // watched outputs
  input wire logic [PC_W-1:0] PM_ADDR_O,
  input wire mis_pkg::mis_dm_s DM_O,
  input wire logic [7:0] ACC_O,
  input wire mis_pkg::mis_flags_s FLAGS_O,
  input wire logic HALT_O,
  input wire logic WDT_CLR_O,
  input wire logic CYCLE_END_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // three quiet clocks, then the next cycle end
  sequence s_gap;
    !CYCLE_END_O [*3] ##1 CYCLE_END_O;
  endsequence
  a_cycle_period: assert property (CYCLE_END_O |=> s_gap) else $error("cycle end spacing wrong");
  a_we_in_end: assert property (DM_O.we |-> CYCLE_END_O) else $error("write outside cycle end");
  a_we_single: assert property (DM_O.we |=> !DM_O.we [*3]) else $error("write pulse too long");
  a_acc_at_end: assert property ($changed(ACC_O) |-> $past(CYCLE_END_O)) else $error("acc moved mid cycle");
  a_flag_at_end: assert property ($changed(FLAGS_O) |-> $past(CYCLE_END_O)) else $error("flags moved mid cycle");
  a_addr_stands: assert property ($changed(DM_O.addr) |-> $past(CYCLE_END_O)) else $error("addr moved mid cycle");
  a_halt_holds: assert property (HALT_O && $past(HALT_O) |-> $stable(PM_ADDR_O) && !DM_O.we)
    else $error("activity while halted");
  a_wdt_pulse: assert property ($rose(WDT_CLR_O) |=> !WDT_CLR_O) else $error("watchdog clear too long");
endmodule : mis_chk

bind mis_core mis_chk #(.PC_W(PC_W)) i_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PM_ADDR_O(PM_ADDR_O),
  .DM_O(DM_O), .ACC_O(ACC_O), .FLAGS_O(FLAGS_O), .HALT_O(HALT_O), .WDT_CLR_O(WDT_CLR_O),
  .CYCLE_END_O(CYCLE_END_O));

/* File: tb/mis_mem.sv */
// mis_mem: program and data memory seen by the core.
// assumes the bench loads both arrays while reset is held.
`timescale 1ns/10ps
module mis_mem #(
  parameter int PC_W = 10
) (
  // clock
  input wire logic clk_i,
  // program memory
  input wire logic [PC_W-1:0] pm_addr_i,
  output logic [15:0] pm_data_o,
  // data memory
  input wire mis_pkg::mis_dm_s dm_i,
  output logic [7:0] dm_rdata_o
);
  logic [15:0] pm [2**PC_W];
  logic [7:0] dm [128];
  // combinational reads, as the core samples late in the cycle
  assign pm_data_o = pm[pm_addr_i];
  assign dm_rdata_o = dm[dm_i.addr];
  // plain always: the bench also preloads dm
  always @(posedge clk_i)
  begin
    if (dm_i.we === 1'b1) dm[dm_i.addr] <= dm_i.wdata;
  end
endmodule : mis_mem

/* File: tb/tb.sv */
// tb: program-driven checks of the sequencer core.
// assumes mis_mem answers the core's memory ports.
`timescale 1ns/10ps
module tb;
  logic clk, rst_n, wake, halt, int_en, wdt, cyc;
  logic [9:0] pm_addr;
  logic [15:0] pm_data;
  logic [7:0] dm_rd, acc, tbl;
  mis_pkg::mis_dm_s dm;
  mis_pkg::mis_flags_s flags;
  int n_mismatch = 0;
  int checked = 0;
  mis_core i_dut (.CLK_I(clk), .RST_N_I(rst_n), .PM_ADDR_O(pm_addr), .PM_DATA_I(pm_data), .DM_O(dm),
    .DM_RDATA_I(dm_rd), .WAKE_I(wake), .ACC_O(acc), .FLAGS_O(flags), .TBL_HIGH_O(tbl), .HALT_O(halt),
    .INT_EN_O(int_en), .WDT_CLR_O(wdt), .CYCLE_END_O(cyc));
  mis_mem i_mem (.clk_i(clk), .pm_addr_i(pm_addr), .pm_data_o(pm_data), .dm_i(dm), .dm_rdata_o(dm_rd));
  // 100 MHz
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic put(input int a, input mis_pkg::mis_op_e op, input logic [9:0] f);
    i_mem.pm[a] = {op, f};
  endtask : put
  // reset held two clocks, memories cleared meanwhile
  task automatic start;
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 1024; i++) i_mem.pm[i] = 16'h0000;
    for (int i = 0; i < 128; i++) i_mem.dm[i] = 8'h00;
  endtask : start
  // release reset, count whole cycles until halt shows
  task automatic go(input int exp_n);
    int n;
    n = 0;
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 400 && halt !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
      if (cyc === 1'b1) n++;
    end
    chk(n, exp_n);
    chk(halt, 1'b1);
  endtask : go
  task automatic t_move;
    start;
    put(0, mis_pkg::OP_XFER_A_X, 10'h0F0);
    put(1, mis_pkg::OP_ADD_A_X, 10'h020);
    put(2, mis_pkg::OP_XFER_M_A, 10'h010);
    put(3, mis_pkg::OP_SUB_A_X, 10'h011);
    put(4, mis_pkg::OP_PLUS1_ACC, 10'h010);
    put(5, mis_pkg::OP_HALT, 10'h000);
    go(7);
    chk(i_mem.dm[16], 8'h10);
    chk(acc, 8'h11);
    chk(flags, 2'h0);
    chk(int_en, 1'b0);
  endtask : t_move
  task automatic t_logic;
    start;
    put(0, mis_pkg::OP_XFER_A_X, 10'h05A);
    put(1, mis_pkg::OP_XOR_A_X, 10'h05A);
    put(2, mis_pkg::OP_OR_A_X, 10'h00F);
    put(3, mis_pkg::OP_XFER_M_A, 10'h011);
    put(4, mis_pkg::OP_INVERT_MEM, 10'h011);
    put(5, mis_pkg::OP_AND_A_M, 10'h011);
    put(6, mis_pkg::OP_HALT, 10'h000);
    go(8);
    chk(i_mem.dm[17], 8'hF0);
    chk(acc, 8'h00);
    chk(flags.z, 1'b1);
  endtask : t_logic
  task automatic t_rot;
    start;
    i_mem.dm[18] = 8'h81;
    put(0, mis_pkg::OP_XFER_A_X, 10'h0FF);
    put(1, mis_pkg::OP_ADD_A_X, 10'h001);
    put(2, mis_pkg::OP_ROT_RC, 10'h012);
    put(3, mis_pkg::OP_ROT_L, 10'h012);
    put(4, mis_pkg::OP_SET_BIT, 10'h092);
    put(5, mis_pkg::OP_CLR_BIT, 10'h392);
    put(6, mis_pkg::OP_ROT_LC, 10'h012);
    put(7, mis_pkg::OP_HALT, 10'h000);
    go(9);
    chk(i_mem.dm[18], 8'h07);
    chk(flags, 2'h2);
  endtask : t_rot
  // call, return, skip taken and not, goto, pc low write
  task automatic t_branch;
    start;
    put(0, mis_pkg::OP_CALL, 10'h005);
    put(1, mis_pkg::OP_SKIP_ZERO, 10'h013);
    put(2, mis_pkg::OP_XFER_A_X, 10'h0EE);
    put(3, mis_pkg::OP_SKIP_BIT1, 10'h013);
    put(4, mis_pkg::OP_GOTO, 10'h008);
    put(5, mis_pkg::OP_XFER_A_X, 10'h033);
    put(6, mis_pkg::OP_SUB_RETURN, 10'h000);
    put(8, mis_pkg::OP_XFER_A_X, 10'h00B);
    put(9, mis_pkg::OP_XFER_M_A, 10'h006);
    put(10, mis_pkg::OP_XFER_A_X, 10'h0EE);
    put(11, mis_pkg::OP_HALT, 10'h000);
    go(15);
    chk(acc, 8'h0B);
    chk(i_mem.dm[19], 8'h00);
    chk(i_mem.dm[6], 8'h00);
  endtask : t_branch
  // remaining opcodes, pc low byte read, interrupt return, taken bit-clear skip
  task automatic t_more;
    start;
    i_mem.dm[33] = 8'h90;
    i_mem.dm[34] = 8'h0F;
    put(0, mis_pkg::OP_CALL, 10'h040);
    put(64, mis_pkg::OP_INT_RETURN, 10'h000);
    put(1, mis_pkg::OP_XFER_A_M, 10'h006);
    put(2, mis_pkg::OP_ADD_A_M, 10'h021);
    put(3, mis_pkg::OP_ADD_M_A, 10'h021);
    put(4, mis_pkg::OP_ADC_A_M, 10'h022);
    put(5, mis_pkg::OP_SBC_A_M, 10'h022);
    put(6, mis_pkg::OP_SUB_A_M, 10'h021);
    put(7, mis_pkg::OP_AND_M_A, 10'h022);
    put(8, mis_pkg::OP_OR_M_A, 10'h022);
    put(9, mis_pkg::OP_XOR_M_A, 10'h021);
    put(10, mis_pkg::OP_OR_A_M, 10'h021);
    put(11, mis_pkg::OP_XOR_A_M, 10'h022);
    put(12, mis_pkg::OP_AND_A_X, 10'h0FE);
    put(13, mis_pkg::OP_PLUS1_MEM, 10'h022);
    put(14, mis_pkg::OP_MINUS1_MEM, 10'h021);
    put(15, mis_pkg::OP_MINUS1_ACC, 10'h021);
    put(16, mis_pkg::OP_INVERT_ACC, 10'h021);
    put(17, mis_pkg::OP_ROT_R, 10'h022);
    put(18, mis_pkg::OP_SKIP_BIT0, 10'h122);
    put(19, mis_pkg::OP_XFER_A_X, 10'h0EE);
    put(20, mis_pkg::OP_NOP, 10'h000);
    put(21, mis_pkg::OP_HALT, 10'h000);
    go(26);
    chk(acc, 8'hAF);
    chk(i_mem.dm[33], 8'h50);
    chk(i_mem.dm[34], 8'hB8);
    chk(flags, 2'h1);
    chk(int_en, 1'b1);
  endtask : t_more
  // table fetch, then wake into a watchdog clear
  task automatic t_table;
    logic seen;
    seen = 1'b0;
    start;
    i_mem.pm[32] = 16'hA55A;
    put(0, mis_pkg::OP_XFER_A_X, 10'h020);
    put(1, mis_pkg::OP_TABLE_READ, 10'h014);
    put(2, mis_pkg::OP_HALT, 10'h000);
    put(3, mis_pkg::OP_WDT_CLEAR, 10'h000);
    put(4, mis_pkg::OP_HALT, 10'h000);
    go(5);
    chk(i_mem.dm[20], 8'h5A);
    chk(tbl, 8'hA5);
    @(posedge clk);
    wake <= 1'b1;
    for (int i = 0; i < 40 && !seen; i++)
    begin
      @(posedge clk);
      #1;
      if (wdt === 1'b1) seen = 1'b1;
    end
    @(posedge clk);
    wake <= 1'b0;
    chk(seen, 1'b1);
  endtask : t_table
  initial
  begin
    rst_n = 1'b0;
    wake = 1'b0;
    t_move;
    t_logic;
    t_rot;
    t_branch;
    t_more;
    t_table;
    tally_and_finish;
  end
  // hang guard, far beyond the few hundred cycles used
  initial
  begin
    #100000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule : tb
